// [design/uiic_char_timer.sv]
`timescale 1ns/1ps
// counts idle character times; restarts on receive fifo read or character arrival
module uiic_char_timer #(
	parameter int CW = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic baud_tick,
	input wire logic [CW-1:0] ticks_per_char,
	input wire logic restart,
	output logic idle_done
);
	logic [CW-1:0] tick_q; // ticks within current character
	logic [2:0] chars_q; // whole characters elapsed

	// per-character counting from the baud enable
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_q <= '0;
			chars_q <= '0;
		end else if (restart) begin
			tick_q <= '0;
			chars_q <= '0;
		end else if (baud_tick && chars_q != uiic_pkg::IDLE_CHARS) begin
			// saturate at four, so the event fires once per idle stretch
			if (tick_q + 1'b1 >= ticks_per_char) begin
				tick_q <= '0;
				chars_q <= chars_q + 3'h1;
			end else begin
				tick_q <= tick_q + 1'b1;
			end
		end
	end

	// one-cycle pulse as the fourth character completes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			idle_done <= 1'b0;
		end else begin
			idle_done <= !restart && baud_tick && chars_q == uiic_pkg::IDLE_CHARS - 3'h1
				&& tick_q + 1'b1 >= ticks_per_char;
		end
	end
endmodule

// [design/uiic_pkg.sv]
// Functional notes
// - line status errors raise code 0110, priority one
// - overrun clears on status read; others when drained
// - non-fifo data ready code 0100, cleared by read
// - fifo data ready follows trigger level reached
// - four idle character times reassert data ready
// - fifo timeout code 1100 when idle, nonempty
// - timeout cleared by read, arrival, receiver reset
// - transmit empty code 0010, holding or fifo
// - transmit empty cleared by write or ident read
// - first fifo read by cpu or dma clears
// - shared address: read ident, write fifo control
// - fifo control fields ignored unless enable set
// - pending indicator low while enabled interrupt pending
// - trigger field selects 1, 4, 8, 14 bytes
package uiic_pkg;
	// identification codes, low nibble of the ident register
	localparam logic [3:0] ID_NONE = 4'h1;
	localparam logic [3:0] ID_LINE = 4'h6;
	localparam logic [3:0] ID_RXDATA = 4'h4;
	localparam logic [3:0] ID_TIMEOUT = 4'hc;
	localparam logic [3:0] ID_THRE = 4'h2;
	// fifo control field positions
	localparam int FC_FIFO_ENABLE_BIT = 0;
	localparam int FC_RXCLR = 1;
	localparam int FC_TXCLR = 2;
	localparam int FC_DMAMODE = 3;
	localparam int FC_TRIG_LO = 6;
	// reset values
	localparam logic [7:0] FC_RESET = 8'h00;
	localparam logic [1:0] FIFO_ENABLE_BIT_ON = 2'h3;
	// trigger depths
	localparam logic [4:0] TRIG_0 = 5'h01;
	localparam logic [4:0] TRIG_1 = 5'h04;
	localparam logic [4:0] TRIG_2 = 5'h08;
	localparam logic [4:0] TRIG_3 = 5'h0e;
	// idle interval in character times
	localparam logic [2:0] IDLE_CHARS = 3'h4;
endpackage

// [design/uiic_top.sv]
`timescale 1ns/1ps
// interrupt identification, clearing and fifo control for the uart
module uiic_top #(
	parameter int CW = 16, // character timer width
	parameter int DW = 5 // fifo level width
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic baud_tick, // one-cycle enable at the bit rate
	input wire logic [CW-1:0] ticks_per_char, // bit times per frame, from format
	input wire logic ie_line, // interrupt enables
	input wire logic ie_rx,
	input wire logic ie_thre,
	input wire logic ovr_err, // error events, one-cycle pulses
	input wire logic err_in_fifo, // parity/framing/break data still queued
	input wire logic line_status_rd,
	input wire logic rx_char_in, // character arrives at receiver
	input wire logic [DW-1:0] rx_level, // receive fifo fill
	input wire logic rx_rd_cpu, // receive buffer read by cpu
	input wire logic rx_rd_dma, // receive buffer read by dma
	input wire logic tx_empty, // holding register or fifo empty
	input wire logic tx_wr, // character written to transmit holding
	input wire logic rx_reset_wr0, // receiver reset control written with 0
	input wire logic ident_rd, // read at shared address
	input wire logic fc_wr, // write at shared address
	input wire logic [7:0] fc_wdata,
	output logic [7:0] ident_rdata,
	output logic fifo_mode,
	output logic [4:0] trig_depth,
	output logic dma_mode,
	output logic rx_clear,
	output logic tx_clear,
	output logic irq_pending_n
);
	logic rst_s1_q; // reset release synchroniser
	logic rst_s2_q;
	logic fen_q; // fifo enable bit
	logic [1:0] trig_q; // receive trigger field
	logic dma_q;
	logic line_q; // line status pending
	logic rxrdy_nf_q; // non-fifo data ready pending
	logic rxrdy_re_q; // fifo data ready reasserted after idle
	logic tout_q; // receiver timeout pending
	logic thre_q; // transmit empty pending
	logic tx_empty_q; // previous empty, for edge detect
	logic rx_rd;
	logic trig_hit;
	logic idle_done;
	logic rx_int;
	logic [3:0] code;
	logic [7:0] ident_d;

	// reset assert async, release through two flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end

	assign rx_rd = rx_rd_cpu | rx_rd_dma;

	// fifo control write; fields need enable set in the same write
	always_ff @(posedge clk or negedge rst_s2_q) begin
		if (!rst_s2_q) begin
			fen_q <= uiic_pkg::FC_RESET[uiic_pkg::FC_FIFO_ENABLE_BIT];
			trig_q <= uiic_pkg::FC_RESET[uiic_pkg::FC_TRIG_LO +: 2];
			dma_q <= uiic_pkg::FC_RESET[uiic_pkg::FC_DMAMODE];
			rx_clear <= 1'b0;
			tx_clear <= 1'b0;
		end else begin
			rx_clear <= 1'b0;
			tx_clear <= 1'b0;
			if (fc_wr) begin
				fen_q <= fc_wdata[uiic_pkg::FC_FIFO_ENABLE_BIT];
				// clearing enable flushes both fifos
				if (!fc_wdata[uiic_pkg::FC_FIFO_ENABLE_BIT]) begin
					rx_clear <= fen_q;
					tx_clear <= fen_q;
				end else begin
					trig_q <= fc_wdata[uiic_pkg::FC_TRIG_LO +: 2];
					dma_q <= fc_wdata[uiic_pkg::FC_DMAMODE];
					rx_clear <= fc_wdata[uiic_pkg::FC_RXCLR];
					tx_clear <= fc_wdata[uiic_pkg::FC_TXCLR];
				end
			end
		end
	end

	// trigger decode
	always_comb begin
		case (trig_q)
			2'h0: trig_depth = uiic_pkg::TRIG_0;
			2'h1: trig_depth = uiic_pkg::TRIG_1;
			2'h2: trig_depth = uiic_pkg::TRIG_2;
			default: trig_depth = uiic_pkg::TRIG_3;
		endcase
	end

	assign trig_hit = fen_q && rx_level >= DW'(trig_depth);
	assign fifo_mode = fen_q;
	assign dma_mode = dma_q;

	// idle character timer, restarted by a receive read, a character arrival, or fifo disable
	uiic_char_timer #(.CW(CW)) u_timer (
		.clk(clk),
		.rst_n(rst_s2_q),
		.baud_tick(baud_tick),
		.ticks_per_char(ticks_per_char),
		.restart(rx_rd | rx_char_in | !fen_q),
		.idle_done(idle_done)
	);

	// line status pending; a new error beats a same-cycle clear
	always_ff @(posedge clk or negedge rst_s2_q) begin
		if (!rst_s2_q) begin
			line_q <= 1'b0;
		end else if (ovr_err) begin
			line_q <= 1'b1;
		end else if (line_status_rd && !err_in_fifo) begin
			line_q <= 1'b0;
		end
	end

	// non-fifo data ready: set on arrival, read clears
	always_ff @(posedge clk or negedge rst_s2_q) begin
		if (!rst_s2_q) begin
			rxrdy_nf_q <= 1'b0;
		end else if (fen_q) begin
			rxrdy_nf_q <= 1'b0;
		end else if (rx_char_in) begin
			rxrdy_nf_q <= 1'b1;
		end else if (rx_rd) begin
			rxrdy_nf_q <= 1'b0;
		end
	end

	// fifo data ready reassert and timeout after four idle characters
	always_ff @(posedge clk or negedge rst_s2_q) begin
		if (!rst_s2_q) begin
			rxrdy_re_q <= 1'b0;
			tout_q <= 1'b0;
		end else if (!fen_q || rx_rd || rx_char_in || rx_reset_wr0) begin
			rxrdy_re_q <= 1'b0;
			tout_q <= 1'b0;
		end else if (idle_done && rx_level != '0) begin
			rxrdy_re_q <= trig_hit;
			tout_q <= 1'b1;
		end
	end

	// transmit empty: set on empty edge, write or ident read clears
	always_ff @(posedge clk or negedge rst_s2_q) begin
		if (!rst_s2_q) begin
			tx_empty_q <= 1'b0;
			thre_q <= 1'b0;
		end else begin
			tx_empty_q <= tx_empty;
			if (tx_empty && !tx_empty_q) begin
				thre_q <= 1'b1;
			end else if (tx_wr || (ident_rd && code == uiic_pkg::ID_THRE)) begin
				thre_q <= 1'b0;
			end
		end
	end

	// rx data ready level in fifo mode follows trigger directly
	assign rx_int = ie_rx && (rxrdy_nf_q || (trig_hit && !tout_q) || rxrdy_re_q);

	// priority encode of enabled sources
	always_comb begin
		if (ie_line && line_q) begin
			code = uiic_pkg::ID_LINE;
		end else if (ie_rx && tout_q) begin
			code = uiic_pkg::ID_TIMEOUT;
		end else if (rx_int) begin
			code = uiic_pkg::ID_RXDATA;
		end else if (ie_thre && thre_q) begin
			code = uiic_pkg::ID_THRE;
		end else begin
			code = uiic_pkg::ID_NONE;
		end
	end

	assign ident_d = {fen_q ? uiic_pkg::FIFO_ENABLE_BIT_ON : 2'h0, 2'h0, code};

	// registered ident content and pending pin
	always_ff @(posedge clk or negedge rst_s2_q) begin
		if (!rst_s2_q) begin
			ident_rdata <= {4'h0, uiic_pkg::ID_NONE};
			irq_pending_n <= 1'b1;
		end else begin
			ident_rdata <= ident_d;
			irq_pending_n <= code[0];
		end
	end

	property p_pend;
		@(posedge clk) disable iff (!rst_s2_q) (code != uiic_pkg::ID_NONE) |=> !irq_pending_n;
	endproperty
	a_pend: assert property (p_pend) else $error("pending not driven low");
	property p_line;
		@(posedge clk) disable iff (!rst_s2_q) ovr_err |=> line_q;
	endproperty
	a_line: assert property (p_line) else $error("overrun not latched");
	property p_prio;
		@(posedge clk) disable iff (!rst_s2_q) (ie_line && line_q) |-> code == uiic_pkg::ID_LINE;
	endproperty
	a_prio: assert property (p_prio) else $error("line status not first");
	property p_thre_clr;
		@(posedge clk) disable iff (!rst_s2_q) (tx_wr && !(tx_empty && !tx_empty_q)) |=> !thre_q;
	endproperty
	a_thre_clr: assert property (p_thre_clr) else $error("thre not cleared");
	property p_tout_clr;
		@(posedge clk) disable iff (!rst_s2_q) (rx_rd || rx_char_in || rx_reset_wr0) |=> !tout_q;
	endproperty
	a_tout_clr: assert property (p_tout_clr) else $error("timeout not cleared");
	property p_tout_set;
		@(posedge clk) disable iff (!rst_s2_q)
			(idle_done && fen_q && rx_level != '0 && !rx_rd && !rx_char_in && !rx_reset_wr0) |=> tout_q;
	endproperty
	a_tout_set: assert property (p_tout_set) else $error("timeout missed");
	property p_fcr_gate;
		@(posedge clk) disable iff (!rst_s2_q) (fc_wr && !fc_wdata[0]) |=> $stable(trig_q);
	endproperty
	a_fcr_gate: assert property (p_fcr_gate) else $error("trigger written without enable");
	property p_nf_clr;
		@(posedge clk) disable iff (!rst_s2_q) (rx_rd && !rx_char_in) |=> !rxrdy_nf_q;
	endproperty
	a_nf_clr: assert property (p_nf_clr) else $error("data ready not cleared");
	// idle interval ends with the fifo at or above trigger and no access in that cycle
	sequence s_idle_at_trig;
		idle_done && trig_hit && rx_level != '0 && !rx_rd && !rx_char_in && !rx_reset_wr0;
	endsequence
	// data ready must be latched again, not left to the level compare alone
	property p_reassert;
		@(posedge clk) disable iff (!rst_s2_q) s_idle_at_trig |=> rxrdy_re_q;
	endproperty
	a_reassert: assert property (p_reassert) else $error("data ready not reasserted after idle");
endmodule

// [dv/uiic_host.sv]
`timescale 1ns/1ps
// cpu and dma side: one-cycle register strobes toward the block
module uiic_host (
	input wire logic clk,
	output logic [6:0] st,
	output logic [7:0] fc_wdata
);
	// last written data, so the idle bus never repeats it
	logic [7:0] last;
	initial begin
		st = 7'h00;
		fc_wdata = 8'h00;
		last = 8'h00;
	end
	// strobe held for exactly one sampling edge
	task automatic acc(input logic [6:0] s, input logic [7:0] d);
		@(posedge clk) #1;
		st = s;
		fc_wdata = d;
		last = d;
		@(posedge clk) #1;
		st = 7'h00;
		fc_wdata = ~last;
	endtask
endmodule

// [dv/uiic_top_tb.sv]
`timescale 1ns/1ps
module uiic_top_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic baud_tick = 1'b0;
	logic ie_line = 1'b1, ie_rx = 1'b1, ie_thre = 1'b1; // interrupt enables
	logic ovr_err = 1'b0, err_in_fifo = 1'b0, rx_char_in = 1'b0, tx_empty = 1'b0;
	logic [4:0] rx_level = 5'h00;
	logic [6:0] st;
	logic [7:0] fc_wdata, ident_rdata;
	logic fifo_mode, dma_mode, rx_clear, tx_clear, irq_pending_n;
	logic [4:0] trig_depth;
	logic [4:0] tl [4] = '{5'h01, 5'h04, 5'h08, 5'h0e}; // expected trigger depths
	logic [8:0] q [$]; // expected {pending_n, ident}
	int n_mismatch = 0, compares = 0, bc = 0;
	event look;
	always #4 clk = ~clk;
	// bit rate a quarter of the clock keeps idle waits short
	always @(posedge clk) begin
		#1 baud_tick = (bc % 4 == 3);
		bc++;
	end
	uiic_host h (.clk(clk), .st(st), .fc_wdata(fc_wdata));
	uiic_top dut (.clk(clk), .rst_n(rst_n), .baud_tick(baud_tick), .ticks_per_char(16'h0002),
		.ie_line(ie_line), .ie_rx(ie_rx), .ie_thre(ie_thre), .ovr_err(ovr_err), .err_in_fifo(err_in_fifo),
		.line_status_rd(st[1]), .rx_char_in(rx_char_in), .rx_level(rx_level), .rx_rd_cpu(st[2]),
		.rx_rd_dma(st[3]), .tx_empty(tx_empty), .tx_wr(st[4]), .rx_reset_wr0(st[5]), .ident_rd(st[0]),
		.fc_wr(st[6]), .fc_wdata(fc_wdata), .ident_rdata(ident_rdata), .fifo_mode(fifo_mode),
		.trig_depth(trig_depth), .dma_mode(dma_mode), .rx_clear(rx_clear), .tx_clear(tx_clear),
		.irq_pending_n(irq_pending_n));
	task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		if (n_mismatch == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// note the expected ident, then let the two-edge answer settle
	task automatic expect_id(input logic [7:0] v);
		q.push_back({v[3:0] == uiic_pkg::ID_NONE, v});
		repeat (3) @(posedge clk);
		#2 -> look;
	endtask
	// watcher: oldest note against what the block shows
	always @(look) chk({irq_pending_n, ident_rdata}, q.pop_front());
	task automatic line(ref logic s);
		@(posedge clk) #1 s = 1'b1;
		@(posedge clk) #1 s = 1'b0;
	endtask
	// bounded wait for the idle timeout code
	task automatic wait_code;
		int i;
		for (i = 0; i < 400 && ident_rdata[3:0] !== uiic_pkg::ID_TIMEOUT; i++) @(posedge clk) #1;
		if (i == 400) begin
			n_mismatch++;
			tally_and_finish();
		end
	endtask
	initial begin
		void'($urandom(34187));
		repeat (2) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (4) @(posedge clk);
		expect_id(8'h01);
		line(ovr_err);
		expect_id(8'h06);
		@(posedge clk) #1 err_in_fifo = 1'b1;
		h.acc(7'h02, 8'h00);
		expect_id(8'h06);
		@(posedge clk) #1 err_in_fifo = 1'b0;
		h.acc(7'h02, 8'h00);
		expect_id(8'h01);
		@(posedge clk) #1 tx_empty = 1'b1;
		expect_id(8'h02);
		line(ovr_err);
		expect_id(8'h06);
		h.acc(7'h02, 8'h00);
		expect_id(8'h02);
		h.acc(7'h01, 8'h00);
		expect_id(8'h01);
		@(posedge clk) #1 tx_empty = 1'b0;
		@(posedge clk) #1 tx_empty = 1'b1;
		expect_id(8'h02);
		h.acc(7'h10, 8'h00);
		expect_id(8'h01);
		// empty edge while transmit interrupt disabled: no pending shown
		@(posedge clk) #1 {ie_thre, tx_empty} = 2'b00;
		@(posedge clk) #1 tx_empty = 1'b1;
		expect_id(8'h01);
		@(posedge clk) #1 ie_thre = 1'b1;
		expect_id(8'h02);
		h.acc(7'h10, 8'h00);
		expect_id(8'h01);
		line(rx_char_in);
		expect_id(8'h04);
		h.acc(7'h04, 8'h00);
		expect_id(8'h01);
		// fields written without the enable must not land
		h.acc(7'h40, 8'hc8);
		chk({7'h0, rx_clear, tx_clear}, 9'h000);
		repeat (2) @(posedge clk);
		#2 chk({2'h0, fifo_mode, dma_mode, trig_depth}, {4'h0, 5'h01});
		for (int k = 0; k < 4; k++) begin
			h.acc(7'h40, {k[1:0], 6'h0f});
			chk({7'h0, rx_clear, tx_clear}, 9'h003);
			repeat (2) @(posedge clk);
			#2 chk({2'h0, fifo_mode, dma_mode, trig_depth}, {4'h3, tl[k]});
			expect_id(8'hc1);
		end
		h.acc(7'h40, 8'h49);
		// a level rise comes with a character arrival, which restarts the idle count
		@(posedge clk) #1 rx_level = 5'h04;
		line(rx_char_in);
		expect_id(8'hc4);
		@(posedge clk) #1 rx_level = 5'h01 + 5'($urandom % 3);
		expect_id(8'hc1);
		wait_code();
		expect_id(8'hcc);
		h.acc(7'h08, 8'h00);
		expect_id(8'hc1);
		wait_code();
		line(rx_char_in);
		expect_id(8'hc1);
		wait_code();
		h.acc(7'h20, 8'h00);
		expect_id(8'hc1);
		// idle at trigger level: timeout shown over the reasserted data ready
		@(posedge clk) #1 rx_level = 5'h04;
		line(rx_char_in);
		wait_code();
		expect_id(8'hcc);
		h.acc(7'h20, 8'h00);
		expect_id(8'hc4);
		// dropping the enable flushes both fifos and leaves fifo mode
		h.acc(7'h40, 8'h00);
		chk({7'h0, rx_clear, tx_clear}, 9'h003);
		expect_id(8'h01);
		tally_and_finish();
	end
endmodule
